// *** inc/prt_pkg.sv ***
// Package with register map, field layout and widths of the prescaled reload timer.
package prt_pkg;
	// Widths of the two counting stages and of the register address and data.
	localparam int PRE_W  = 12;
	localparam int STEP_W = PRE_W + 1;
	localparam int CNT_W  = 16;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	// Rate of the core clock that every timer interval is counted in.
	localparam int unsigned CLK_HZ = 20_000_000;

	// Register byte offsets.
	localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_MODE = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_PRE  = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_RLD  = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_VAL  = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_STAT = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_EVT  = 8'h18;
	localparam logic [ADDR_W-1:0] OFF_MASK = 8'h1c;

	// Field positions.
	localparam int CTRL_START  = 0;
	localparam int CTRL_STOP   = 1;
	localparam int MODE_HI_MSB = 3;
	localparam int MODE_EVEN   = 4;
	localparam int MODE_PERIOD = 5;
	localparam int MODE_AUTO   = 7;
	localparam int STAT_RUN    = 0;
	localparam int EVT_TIMER   = 0;
	localparam int EVT_SET     = 7;

	// Reset values and bus responses.
	localparam logic [7:0]        MODE_RST = 8'h00;
	localparam logic [7:0]        PRE_RST  = 8'h00;
	localparam logic [CNT_W-1:0]  RLD_RST  = 16'h0000;
	localparam logic [1:0]        RESP_OK  = 2'h0;
	localparam logic [1:0]        RESP_ERR = 2'h2;
endpackage

// *** inc/prt_if.sv ***
// Interfaces between the timer top, its counting stages and its bus slave.
interface prt_stage_if #(parameter int W = 16);
	logic         load;
	logic         step;
	logic         auto;
	logic [W-1:0] reload;
	logic [W-1:0] count;
	logic         expire;
	logic         reach_zero;
	modport stage(input load, step, auto, reload, output count, expire, reach_zero);
	modport ctrl(output load, step, auto, reload, input count, expire, reach_zero);
endinterface

interface prt_reg_if;
	logic        wr;
	logic [7:0]  waddr;
	logic [31:0] wdata;
	logic [3:0]  wstrb;
	logic        wr_ok;
	logic        rd;
	logic [7:0]  raddr;
	logic [31:0] rdata;
	logic        rd_ok;
	modport bus(output wr, waddr, wdata, wstrb, rd, raddr, input wr_ok, rdata, rd_ok);
	modport regs(input wr, waddr, wdata, wstrb, rd, raddr, output wr_ok, rdata, rd_ok);
endinterface

// *** core/prt_stage.sv ***
// Reloadable down-counting stage used for the prescaler and the main counter.
module prt_stage import prt_pkg::*; #(
	parameter int W = CNT_W
) (
	input wire logic   aclk,    // Core clock.
	input wire logic   aresetn, // Synchronous reset, active low.
	input wire logic   ce,      // Clock enable.
	prt_stage_if.stage st       // Load, step and count.
);
	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;

	// Next count: load wins, a step at zero reloads or holds, else decrement.
	always_comb begin
		cnt_d = cnt_q;
		if (st.load) begin
			cnt_d = st.reload;
		end else if (st.step) begin
			if (cnt_q == '0) begin
				if (st.auto) begin
					cnt_d = st.reload;
				end
			end else begin
				cnt_d = cnt_q - W'(1);
			end
		end
	end

	// Count register.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q <= '0;
		end else if (ce) begin
			cnt_q <= cnt_d;
		end
	end

	// Expiry after reload plus one steps, and the one-to-zero decrement.
	assign st.count      = cnt_q;
	assign st.expire     = st.step && !st.load && (cnt_q == '0);
	assign st.reach_zero = st.step && !st.load && (cnt_q == W'(1));
endmodule // prt_stage

// *** core/prt_axil.sv ***
// AXI4-Lite slave front end that turns bus transfers into register strobes.
module prt_axil import prt_pkg::*; (
	input  wire logic              aclk,    // Core clock.
	input  wire logic              aresetn, // Synchronous reset, active low.
	input  wire logic              ce,      // Clock enable.
	input  wire logic [ADDR_W-1:0] awaddr,  // Write address.
	input  wire logic              awvalid, // Write address valid.
	output logic                   awready, // Write address ready.
	input  wire logic [DATA_W-1:0] wdata,   // Write data.
	input  wire logic [3:0]        wstrb,   // Write byte strobes.
	input  wire logic              wvalid,  // Write data valid.
	output logic                   wready,  // Write data ready.
	output logic [1:0]             bresp,   // Write response.
	output logic                   bvalid,  // Write response valid.
	input  wire logic              bready,  // Write response ready.
	input  wire logic [ADDR_W-1:0] araddr,  // Read address.
	input  wire logic              arvalid, // Read address valid.
	output logic                   arready, // Read address ready.
	output logic [DATA_W-1:0]      rdata,   // Read data.
	output logic [1:0]             rresp,   // Read response.
	output logic                   rvalid,  // Read data valid.
	input  wire logic              rready,  // Read data ready.
	prt_reg_if.bus                 rg       // Register strobes.
);
	logic              aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
	logic [ADDR_W-1:0] awa_q, awa_d;
	logic [DATA_W-1:0] wd_q, wd_d, rd_q, rd_d;
	logic [3:0]        ws_q, ws_d;
	logic [1:0]        br_q, br_d, rr_q, rr_d;

	// Address and data are held until both are present, then written once.
	always_comb begin
		awready  = ce && !aw_q;
		wready   = ce && !w_q;
		arready  = ce && !rv_q;
		rg.wr    = ce && aw_q && w_q && !bv_q;
		rg.waddr = awa_q;
		rg.wdata = wd_q;
		rg.wstrb = ws_q;
		rg.rd    = ce && arvalid && !rv_q;
		rg.raddr = araddr;
		{aw_d, awa_d, w_d, wd_d, ws_d} = {aw_q, awa_q, w_q, wd_q, ws_q};
		{bv_d, br_d, rv_d, rd_d, rr_d} = {bv_q, br_q, rv_q, rd_q, rr_q};
		if (awvalid && awready) begin
			aw_d  = 1'b1;
			awa_d = awaddr;
		end
		if (wvalid && wready) begin
			w_d  = 1'b1;
			wd_d = wdata;
			ws_d = wstrb;
		end
		if (rg.wr) begin
			aw_d = 1'b0;
			w_d  = 1'b0;
			bv_d = 1'b1;
			br_d = rg.wr_ok ? RESP_OK : RESP_ERR;
		end else if (bv_q && bready) begin
			bv_d = 1'b0;
		end
		if (rg.rd) begin
			rv_d = 1'b1;
			rd_d = rg.rdata;
			rr_d = rg.rd_ok ? RESP_OK : RESP_ERR;
		end else if (rv_q && rready) begin
			rv_d = 1'b0;
		end
	end

	// Channel state registers.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{aw_q, w_q, bv_q, rv_q} <= 4'h0;
			{awa_q, wd_q, ws_q}     <= '0;
			{br_q, rr_q, rd_q}      <= '0;
		end else if (ce) begin
			{aw_q, awa_q, w_q, wd_q, ws_q} <= {aw_d, awa_d, w_d, wd_d, ws_d};
			{bv_q, br_q, rv_q, rd_q, rr_q} <= {bv_d, br_d, rv_d, rd_d, rr_d};
		end
	end

	assign bvalid = bv_q;
	assign bresp  = br_q;
	assign rvalid = rv_q;
	assign rdata  = rd_q;
	assign rresp  = rr_q;
endmodule // prt_axil

// *** core/prt_timer.sv ***
// Top of the prescaled reload timer: registers, start and stop control, events, checks.
//
// Our own choices: the register offsets and the AXI4-Lite interface to the registers.
module prt_timer import prt_pkg::*; (
	input  wire logic              aclk,        // Core clock.
	input  wire logic              aresetn,     // Synchronous reset, active low.
	input  wire logic              ce,          // Clock enable, freezes all state.
	input  wire logic              proto_event, // Protocol start event, same clock.
	input  wire logic [ADDR_W-1:0] awaddr,      // Write address.
	input  wire logic              awvalid,     // Write address valid.
	output logic                   awready,     // Write address ready.
	input  wire logic [DATA_W-1:0] wdata,       // Write data.
	input  wire logic [3:0]        wstrb,       // Write byte strobes.
	input  wire logic              wvalid,      // Write data valid.
	output logic                   wready,      // Write data ready.
	output logic [1:0]             bresp,       // Write response.
	output logic                   bvalid,      // Write response valid.
	input  wire logic              bready,      // Write response ready.
	input  wire logic [ADDR_W-1:0] araddr,      // Read address.
	input  wire logic              arvalid,     // Read address valid.
	output logic                   arready,     // Read address ready.
	output logic [DATA_W-1:0]      rdata,       // Read data.
	output logic [1:0]             rresp,       // Read response.
	output logic                   rvalid,      // Read data valid.
	input  wire logic              rready,      // Read data ready.
	output logic                   irq          // Level interrupt, active high.
);
	prt_reg_if               rg();
	prt_stage_if #(.W(STEP_W)) pre();
	prt_stage_if #(.W(CNT_W))  mst();

	logic [7:0]       mode_q, mode_d, pre_q, pre_d, mask_q, mask_d;
	logic [CNT_W-1:0] rld_q, rld_d;
	logic             evt_q, evt_d, run_q, run_d;
	logic             sw_start, sw_stop, start, evt_set, evt_clr, evt_rd, periodic;

	// Bus slave front end.
	prt_axil u_bus (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ce      (ce),
		.awaddr  (awaddr),
		.awvalid (awvalid),
		.awready (awready),
		.wdata   (wdata),
		.wstrb   (wstrb),
		.wvalid  (wvalid),
		.wready  (wready),
		.bresp   (bresp),
		.bvalid  (bvalid),
		.bready  (bready),
		.araddr  (araddr),
		.arvalid (arvalid),
		.arready (arready),
		.rdata   (rdata),
		.rresp   (rresp),
		.rvalid  (rvalid),
		.rready  (rready),
		.rg      (rg.bus)
	);

	// Prescaler: steps on every core clock while running; its reload doubles the
	// prescale value and adds the even bit, so one step lasts 2P+1 or 2P+2 clocks.
	assign pre.load   = start;
	assign pre.step   = run_q;
	assign pre.auto   = 1'b1;
	assign pre.reload = {mode_q[MODE_HI_MSB:0], pre_q, mode_q[MODE_EVEN]};

	// Main counter: one step per prescaler expiry, a decrement or, at zero when periodic, a reload.
	assign periodic   = mode_q[MODE_PERIOD];
	assign mst.load   = start;
	assign mst.step   = pre.expire;
	assign mst.auto   = periodic;
	assign mst.reload = rld_q;

	prt_stage #(.W(STEP_W)) u_pre (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ce      (ce),
		.st      (pre.stage)
	);

	prt_stage #(.W(CNT_W)) u_mst (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ce      (ce),
		.st      (mst.stage)
	);

	// Address map check for both directions.
	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		mapped = (a == OFF_CTRL) || (a == OFF_MODE) || (a == OFF_PRE) || (a == OFF_RLD)
			|| (a == OFF_VAL) || (a == OFF_STAT) || (a == OFF_EVT) || (a == OFF_MASK);
	endfunction

	assign rg.wr_ok = mapped(rg.waddr);
	assign rg.rd_ok = mapped(rg.raddr);

	// Read data multiplexer; unused bits read as zero.
	always_comb begin
		rg.rdata = '0;
		if (rg.raddr == OFF_MODE) begin
			rg.rdata[7:0] = mode_q;
		end else if (rg.raddr == OFF_PRE) begin
			rg.rdata[7:0] = pre_q;
		end else if (rg.raddr == OFF_RLD) begin
			rg.rdata[CNT_W-1:0] = rld_q;
		end else if (rg.raddr == OFF_VAL) begin
			rg.rdata[CNT_W-1:0] = mst.count;
		end else if (rg.raddr == OFF_STAT) begin
			rg.rdata[STAT_RUN] = run_q;
		end else if (rg.raddr == OFF_EVT) begin
			rg.rdata[EVT_TIMER] = evt_q;
		end else if (rg.raddr == OFF_MASK) begin
			rg.rdata[7:0] = mask_q;
		end
	end

	// Register writes, start and stop decoding, event flag and running state.
	always_comb begin
		mode_d   = mode_q;
		pre_d    = pre_q;
		rld_d    = rld_q;
		mask_d   = mask_q;
		sw_start = 1'b0;
		sw_stop  = 1'b0;
		evt_set  = 1'b0;
		evt_clr  = 1'b0;
		if (rg.wr) begin
			if (rg.waddr == OFF_CTRL) begin
				if (rg.wstrb[0]) begin
					sw_start = rg.wdata[CTRL_START];
					sw_stop  = rg.wdata[CTRL_STOP];
				end
			end else if (rg.waddr == OFF_MODE) begin
				if (rg.wstrb[0]) begin
					mode_d = rg.wdata[7:0];
				end
			end else if (rg.waddr == OFF_PRE) begin
				if (rg.wstrb[0]) begin
					pre_d = rg.wdata[7:0];
				end
			end else if (rg.waddr == OFF_RLD) begin
				if (rg.wstrb[0]) begin
					rld_d[7:0] = rg.wdata[7:0];
				end
				if (rg.wstrb[1]) begin
					rld_d[15:8] = rg.wdata[15:8];
				end
			end else if (rg.waddr == OFF_EVT) begin
				if (rg.wstrb[0] && rg.wdata[EVT_TIMER]) begin
					evt_set = rg.wdata[EVT_SET];
					evt_clr = !rg.wdata[EVT_SET];
				end
			end else if (rg.waddr == OFF_MASK) begin
				if (rg.wstrb[0]) begin
					mask_d = rg.wdata[7:0];
				end
			end
		end
		start  = sw_start || (mode_q[MODE_AUTO] && proto_event);
		evt_rd = rg.rd && (rg.raddr == OFF_EVT);
		// Hardware set wins over a clear in the same cycle.
		evt_d = evt_q;
		if (evt_clr || evt_rd) begin
			evt_d = 1'b0;
		end
		if (mst.reach_zero || evt_set) begin
			evt_d = 1'b1;
		end
		// Expiry touches only the flag and the running bit, nothing else.
		run_d = run_q;
		if (mst.reach_zero && !periodic) begin
			run_d = 1'b0;
		end
		if (start) begin
			run_d = 1'b1;
		end
		if (sw_stop) begin
			run_d = 1'b0;
		end
	end

	// Control and status registers.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_q <= MODE_RST;
			pre_q  <= PRE_RST;
			rld_q  <= RLD_RST;
			mask_q <= 8'h00;
			evt_q  <= 1'b0;
			run_q  <= 1'b0;
		end else if (ce) begin
			mode_q <= mode_d;
			pre_q  <= pre_d;
			rld_q  <= rld_d;
			mask_q <= mask_d;
			evt_q  <= evt_d;
			run_q  <= run_d;
		end
	end

	// Interrupt level from the masked sticky flag.
	assign irq = evt_q && mask_q[EVT_TIMER];

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence s_one_to_zero;
		ce && run_q && pre.expire && (mst.count == 16'h0001) && !start;
	endsequence

	sequence s_flag_seen;
		evt_q ##0 (irq == mask_q[EVT_TIMER]);
	endsequence

	a_flag_on_zero: assert property (s_one_to_zero |=> s_flag_seen)
		else $error("event flag not set on decrement to zero");
	a_irq_on_zero: assert property (ce && mst.reach_zero && mask_q[EVT_TIMER]
		&& !(rg.wr && rg.waddr == OFF_MASK) |=> irq)
		else $error("interrupt not raised on zero");
	a_halt_at_zero: assert property (s_one_to_zero and (!periodic && !sw_stop)
		|=> !run_q && mst.count == 16'h0000
		##1 (mst.count == 16'h0000 || $past(start)))
		else $error("timer did not halt at zero");
	a_periodic_reload: assert property (ce && periodic && mst.expire
		|=> mst.count == $past(rld_q))
		else $error("counter did not reload in periodic mode");
	a_start_loads: assert property (ce && start && !sw_stop
		|=> run_q && mst.count == $past(rld_q) && pre.count == $past(pre.reload))
		else $error("start did not load both stages");
	a_stop_halts: assert property (ce && sw_stop |=> !run_q)
		else $error("immediate stop did not halt the timer");
	a_auto_start: assert property (ce && mode_q[MODE_AUTO] && proto_event && !sw_stop
		|=> run_q)
		else $error("protocol event did not start the timer");
	a_step_length: assert property (ce && run_q && pre.expire && !start
		|=> pre.count == $past(pre.reload))
		else $error("prescaler did not reload on expiry");
	a_sw_set_flag: assert property (ce && evt_set |=> evt_q)
		else $error("software set of event flag ignored");
	a_sw_clr_flag: assert property (ce && evt_clr && !mst.reach_zero |=> !evt_q)
		else $error("software clear of event flag ignored");
	a_expiry_runs_on: assert property (ce && mst.reach_zero && periodic && !sw_stop
		|=> run_q)
		else $error("expiry stopped a periodic timer");
	a_count_read: assert property (ce && rg.rd && rg.raddr == OFF_VAL
		|=> rdata[CNT_W-1:0] == $past(mst.count))
		else $error("counter value read mismatch");
	a_ce_freeze: assert property (!ce |=> $stable(run_q) && $stable(mst.count) && $stable(evt_q))
		else $error("state changed while clock enable low");
endmodule // prt_timer

// *** tb/prt_host.sv ***
// Host model that masters the AXI4-Lite register bus of the timer.
module prt_host import prt_pkg::*; (
	input  wire logic              aclk,    // Core clock.
	output logic [ADDR_W-1:0]      awaddr,  // Write address.
	output logic                   awvalid, // Address valid.
	input  wire logic              awready, // Address ready.
	output logic [DATA_W-1:0]      wdata,   // Write data.
	output logic [3:0]             wstrb,   // Byte strobes.
	output logic                   wvalid,  // Data valid.
	input  wire logic              wready,  // Data ready.
	input  wire logic [1:0]        bresp,   // Write response.
	input  wire logic              bvalid,  // Response valid.
	output logic                   bready,  // Response ready.
	output logic [ADDR_W-1:0]      araddr,  // Read address.
	output logic                   arvalid, // Address valid.
	input  wire logic              arready, // Address ready.
	input  wire logic [DATA_W-1:0] rdata,   // Read data.
	input  wire logic [1:0]        rresp,   // Read response.
	input  wire logic              rvalid,  // Read valid.
	output logic                   rready   // Read ready.
);
	timeunit 1ns;
	timeprecision 1ps;
	int unsigned cyc = 0;

	// Counts rising edges so callers can time events.
	always @(posedge aclk) begin
		cyc <= cyc + 1;
	end

	// The bus is idle from time zero.
	initial begin
		{awvalid, wvalid, bready, arvalid, rready} <= 5'h00;
		{awaddr, araddr, wdata, wstrb} <= '0;
	end

	// Ready signals are sampled half a cycle before the edge, where they are settled.
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
			output logic [1:0] r, output int unsigned at);
		logic aw_t;
		logic w_t;
		logic b_t;
		b_t = 1'b0;
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= d;
		wstrb   <= 4'hf;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		while (!b_t) begin
			@(negedge aclk);
			aw_t = awvalid & awready;
			w_t  = wvalid & wready;
			b_t  = bvalid;
			r    = bresp;
			at   = cyc;
			@(posedge aclk);
			if (aw_t) awvalid <= 1'b0;
			if (w_t) wvalid <= 1'b0;
		end
		bready <= 1'b0;
	endtask

	// One read; the answer is taken at the edge where rvalid is seen.
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
			output logic [1:0] r);
		logic ar_t;
		logic r_t;
		r_t = 1'b0;
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		while (!r_t) begin
			@(negedge aclk);
			ar_t = arvalid & arready;
			r_t  = rvalid;
			d    = rdata;
			r    = rresp;
			@(posedge aclk);
			if (ar_t) arvalid <= 1'b0;
		end
		rready <= 1'b0;
	endtask
endmodule // prt_host

// *** tb/prt_timer_test.sv ***
// Self-checking testbench of the prescaled reload timer.
module prt_timer_test import prt_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic              aclk, aresetn, ce, proto_event;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [DATA_W-1:0] wdata, rdata;
	logic [3:0]        wstrb;
	logic [1:0]        bresp, rresp;
	logic              awvalid, awready, wvalid, wready, bvalid, bready;
	logic              arvalid, arready, rvalid, rready, irq;
	int                miscompares = 0;
	int                cmp_count = 0;
	logic [31:0]       rng;

	prt_timer uut (.aclk, .aresetn, .ce, .proto_event, .awaddr, .awvalid, .awready, .wdata,
		.wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
		.rdata, .rresp, .rvalid, .rready, .irq);
	prt_host host (.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
		.rready);

	// Free-running 20 MHz clock.
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end

	// Helpers for random draws, expected step length, comparing and closing.
	function automatic logic [31:0] xorshift(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	function automatic int step_len(input int p, input logic ev);
		return 2 * p + 1 + int'(ev);
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	// Register access and waiting helpers built on the host model.
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		logic [1:0]  r;
		int unsigned c;
		host.wr(a, d, r, c);
		check(r, RESP_OK, "write response");
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string msg);
		logic [31:0] d;
		logic [1:0]  r;
		host.rd(a, d, r);
		check(r, RESP_OK, "read response");
		check(d, exp, msg);
	endtask
	task automatic irq_is(input logic exp);
		@(negedge aclk);
		check(irq, exp, "irq level");
	endtask
	task automatic wait_irq(output int unsigned at);
		at = 0;
		for (int i = 0; i < 5000 && at == 0; i++) begin
			@(negedge aclk);
			if (irq === 1'b1) at = host.cyc;
		end
	endtask
	task automatic pulse_event;
		@(posedge aclk);
		proto_event <= 1'b1;
		@(posedge aclk);
		proto_event <= 1'b0;
	endtask
	task automatic start_timer(input int p, input logic ev, input int rl, input logic per,
			output int unsigned s);
		logic [1:0] r;
		wreg(OFF_MODE, {26'h0, per, ev, p[11:8]});
		wreg(OFF_PRE, {24'h0, p[7:0]});
		wreg(OFF_RLD, {16'h0, rl[15:0]});
		wreg(OFF_MASK, 32'h1);
		rchk(OFF_EVT, 32'h0, "event idle");
		host.wr(OFF_CTRL, 32'h1, r, s);
	endtask

	// Main sequence.
	initial begin
		logic [7:0]  offs [8];
		logic [31:0] wm [8];
		logic [31:0] d;
		logic [1:0]  r;
		int unsigned s;
		int unsigned f;
		int unsigned f2;
		int          p;
		int          rl;
		offs = '{OFF_CTRL, OFF_MODE, OFF_PRE, OFF_RLD, OFF_VAL, OFF_STAT, OFF_EVT, OFF_MASK};
		wm = '{32'h0, 32'hff, 32'hff, 32'hffff, 32'h0, 32'h0, 32'h0, 32'hff};
		rng = 32'h48;
		aresetn = 1'b0;
		ce = 1'b1;
		proto_event = 1'b0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 8; i++) rchk(offs[i], 32'h0, "reset value");
		for (int i = 1; i < 8; i++) begin
			rng = xorshift(rng);
			if (i != 6) wreg(offs[i], rng);
			if (i != 6) rchk(offs[i], rng & wm[i], "register width");
		end
		wreg(OFF_MODE, 32'h0);
		host.wr(8'h20, rng, r, s);
		check(r, RESP_ERR, "unmapped write");
		host.rd(8'h20, d, r);
		check(r, RESP_ERR, "unmapped read");
		check(d, 32'h0, "unmapped data");
		$display("test registers done");
		// Halt runs with random prescale, parity and reload; the last one uses the high nibble.
		for (int t = 0; t < 4; t++) begin
			rng = xorshift(rng);
			p = (t == 3) ? 256 : int'(rng[2:0]);
			rl = int'(rng[6:4]) + 1;
			start_timer(p, rng[3], rl, 1'b0, s);
			wait_irq(f);
			check(f - s, rl * step_len(p, rng[3]), "expiry time");
			rchk(OFF_STAT, 32'h0, "halted");
			rchk(OFF_VAL, 32'h0, "count at zero");
			rchk(OFF_EVT, 32'h1, "event set");
			irq_is(1'b0);
		end
		$display("test halt done");
		// Clock enable held low for 20 cycles must stretch the expiry by exactly 20 cycles.
		start_timer(1, 1'b0, 10, 1'b0, s);
		@(posedge aclk);
		ce <= 1'b0;
		repeat (20) @(posedge aclk);
		ce <= 1'b1;
		wait_irq(f);
		check(f - s, 32'd50, "frozen expiry");
		rchk(OFF_EVT, 32'h1, "event after freeze");
		$display("test freeze done");
		// Periodic run: reload period is one step more than the first expiry.
		start_timer(3, 1'b1, 3, 1'b1, s);
		wait_irq(f);
		check(f - s, 32'd24, "first expiry");
		rchk(OFF_EVT, 32'h1, "event set");
		wait_irq(f2);
		check(f2 - f, 32'd32, "period");
		rchk(OFF_STAT, 32'h1, "still running");
		wreg(OFF_CTRL, 32'h2);
		host.rd(OFF_VAL, d, r);
		repeat (20) @(posedge aclk);
		rchk(OFF_VAL, d, "count held");
		rchk(OFF_STAT, 32'h0, "stopped");
		$display("test periodic done");
		// Software set and clear of the event flag, gated by the mask.
		rchk(OFF_EVT, 32'h1, "event left set");
		wreg(OFF_EVT, 32'h81);
		irq_is(1'b1);
		wreg(OFF_MASK, 32'h0);
		irq_is(1'b0);
		wreg(OFF_MASK, 32'h1);
		irq_is(1'b1);
		wreg(OFF_EVT, 32'h01);
		irq_is(1'b0);
		wreg(OFF_EVT, 32'h80);
		rchk(OFF_EVT, 32'h0, "no-op write");
		$display("test event done");
		// Automatic start by protocol event, and start with stop in one write.
		wreg(OFF_RLD, 32'd100);
		wreg(OFF_MODE, 32'h80);
		pulse_event();
		rchk(OFF_STAT, 32'h1, "auto started");
		// A reset in mid-run stops the timer and clears its count.
		@(posedge aclk);
		aresetn <= 1'b0;
		@(posedge aclk);
		aresetn <= 1'b1;
		rchk(OFF_STAT, 32'h0, "reset stops");
		rchk(OFF_VAL, 32'h0, "reset count");
		wreg(OFF_CTRL, 32'h2);
		wreg(OFF_MODE, 32'h0);
		pulse_event();
		rchk(OFF_STAT, 32'h0, "auto off");
		wreg(OFF_CTRL, 32'h3);
		rchk(OFF_STAT, 32'h0, "stop wins");
		$display("test start done");
		finish_test();
	end

	// Cuts a hang short well beyond the expected run length.
	initial begin
		repeat (50000) @(posedge aclk);
		miscompares++;
		$display("mismatch at %0t: run did not end", $time);
		finish_test();
	end
endmodule // prt_timer_test
